/* lad_pkg.sv */
// Constants and types shared by the locality arbiter and its address decoder
package lad_pkg;
	// ======================================================================
	// Level numbering
	localparam int unsigned NUM_LVL = 5;
	localparam logic [2:0] TOP_LVL = 3'h4;
	localparam logic [3:0] MAX_LVL_FIELD = 4'h4;
	localparam logic [4:0] TOP_LVL_OH = 5'h10;
	localparam logic [4:0] NO_LVL_OH = 5'h00;
	localparam logic [7:0] IND_RESET = 8'h00;

	// ======================================================================
	// Offsets inside one level's 4 KiB window
	localparam logic [11:0] OFS_CTRL_LO = 12'h008;
	localparam logic [11:0] OFS_CTRL_HI = 12'h00B;
	localparam logic [11:0] OFS_STS_LO = 12'h018;
	localparam logic [11:0] OFS_STS_HI = 12'h01B;
	localparam logic [9:0] OFS_DATA_WORD = 10'h009;
	localparam logic [11:0] OFS_MSTART = 12'h028;
	localparam logic [11:0] OFS_MEND = 12'h029;
	localparam logic [9:0] OFS_MDATA_WORD = 10'h00B;

	// ======================================================================
	// Control register fields
	localparam int unsigned CTRL_REQ_BIT = 0;
	localparam int unsigned CTRL_REL_BIT = 1;

	// ======================================================================
	// Ownership states
	typedef enum logic [2:0] {
		ST_FREE  = 3'b001,
		ST_OWNED = 3'b010,
		ST_MEAS  = 3'b100
	} lad_state_t;
endpackage

/* lad_decode.sv */
// Address decoder: level window and register selection for one bus address
`timescale 1ns/10ps
`default_nettype none
module lad_decode (
	input  wire logic [15:0] addr,       // Bus address
	output logic      [2:0]  lvl,        // Level of the window
	output logic             lvl_ok,     // Address lies in levels 0 to 4
	output logic             hit_ctrl,   // Level control register
	output logic             hit_sts,    // Shared status register
	output logic             hit_data,   // Aliased data port
	output logic             hit_mstart, // Measurement begin
	output logic             hit_mend,   // Measurement end
	output logic             hit_mdata,  // Measurement data, aliased
	output logic             hit_none    // Nothing decoded
);
	logic [11:0] ofs;
	logic        top;

	// ======================================================================
	// Window selection
	always_comb begin
		ofs = addr[11:0];
		lvl_ok = (addr[15:12] <= lad_pkg::MAX_LVL_FIELD);
		lvl = addr[14:12];
		top = lvl_ok && (lvl == lad_pkg::TOP_LVL);
	end

	// ======================================================================
	// Register selection; each window decodes alone, so ranges of the same
	// function in two levels never merge into one span.
	always_comb begin
		hit_ctrl = lvl_ok && (ofs >= lad_pkg::OFS_CTRL_LO) &&
			(ofs <= lad_pkg::OFS_CTRL_HI);
		hit_sts = lvl_ok && (ofs >= lad_pkg::OFS_STS_LO) &&
			(ofs <= lad_pkg::OFS_STS_HI);
		hit_data = lvl_ok && (ofs[11:2] == lad_pkg::OFS_DATA_WORD);
		hit_mstart = top && (ofs == lad_pkg::OFS_MSTART);
		hit_mend = top && (ofs == lad_pkg::OFS_MEND);
		hit_mdata = top && (ofs[11:2] == lad_pkg::OFS_MDATA_WORD);
		hit_none = !(hit_ctrl || hit_sts || hit_data || hit_mstart ||
			hit_mend || hit_mdata);
	end
endmodule
`default_nettype wire

/* lad_arbiter.sv */
// Locality ownership arbiter with measurement command handling and decode
`timescale 1ns/10ps
`default_nettype none
module lad_arbiter (
	input  wire logic        CLK,               // 25 MHz clock
	input  wire logic        RST_N,             // Async reset, active low
	input  wire logic        ACC_VALID,         // Bus access this cycle
	input  wire logic        ACC_WRITE,         // Access is a write
	input  wire logic [15:0] ACC_ADDR,          // Access address
	input  wire logic [7:0]  ACC_WDATA,         // Write byte
	input  wire logic        CRB_MODE,          // Command-buffer interface
	input  wire logic [4:0]  REQ_LEVEL,         // Request pulses per level
	input  wire logic [4:0]  SEIZE_LEVEL,       // Seize pulses per level
	input  wire logic        RELINQUISH,        // Owner gives up
	input  wire logic        RES_VALID,         // Resource level check
	input  wire logic [4:0]  RES_LEVELS,        // Levels allowed by policy
	output logic      [7:0]  LEVEL_ONEHOT_IND,  // Active level, one-hot
	output logic             OWNED,             // Some level owns device
	output logic             MEAS_ACTIVE,       // Measurement in progress
	output logic             MEAS_START_STB,    // Begin accepted
	output logic             MEAS_END_STB,      // End accepted
	output logic             MEAS_DATA_VALID,   // Measurement byte strobe
	output logic      [7:0]  MEAS_DATA,         // Measurement byte
	output logic             CMD_IGNORED,       // Command dropped
	output logic             RES_GRANT,         // Resource check passed
	output logic             RES_DENY,          // Resource check refused
	output logic             ACC_REFUSED,       // Data port by non-owner
	output logic      [2:0]  ACC_LEVEL,         // Level of last access to levels 0 to 4
	output logic             SEL_CTRL,          // Control register hit
	output logic             SEL_STATUS,        // Shared status hit
	output logic             SEL_DATA,          // Shared data port hit
	output logic             SEL_NONE           // Unmapped access
);
	// ======================================================================
	// Declarations
	lad_pkg::lad_state_t state_r;
	lad_pkg::lad_state_t state_nxt;
	logic [4:0]  act_r;
	logic [4:0]  act_nxt;
	logic [4:0]  req_r;
	logic [4:0]  req_nxt;
	logic [4:0]  grant;
	logic [4:0]  hi_req;
	logic [4:0]  hi_seize;
	logic [4:0]  acc_oh;
	logic [4:0]  ctrl_set;
	logic [2:0]  dec_lvl;
	logic        dec_ok;
	logic        hit_ctrl;
	logic        hit_sts;
	logic        hit_data;
	logic        hit_mstart;
	logic        hit_mend;
	logic        hit_mdata;
	logic        hit_none;
	logic        acc_wr;
	logic        mstart_wr;
	logic        mend_wr;
	logic        mdata_wr;
	logic        ctrl_wr;
	logic        release_req;
	logic        start_ok;
	logic        end_ok;
	logic        ignored;

	// Highest set bit, one-hot; higher level means higher priority
	function automatic logic [4:0] top_bit(input logic [4:0] v);
		logic [4:0] h;
		h = 5'h00;
		for (int i = 0; i < 5; i++) begin
			if (v[i]) begin
				h = 5'(1 << i);
			end
		end
		return h;
	endfunction

	// ======================================================================
	// Address decode
	lad_decode u_dec (
		.addr       (ACC_ADDR),
		.lvl        (dec_lvl),
		.lvl_ok     (dec_ok),
		.hit_ctrl   (hit_ctrl),
		.hit_sts    (hit_sts),
		.hit_data   (hit_data),
		.hit_mstart (hit_mstart),
		.hit_mend   (hit_mend),
		.hit_mdata  (hit_mdata),
		.hit_none   (hit_none)
	);

	always_comb begin
		acc_oh = 5'h00;
		for (int i = 0; i < 5; i++) begin
			acc_oh[i] = dec_ok && (dec_lvl == 3'(i));
		end
		acc_wr = ACC_VALID && ACC_WRITE && dec_ok;
		mstart_wr = acc_wr && hit_mstart;
		mend_wr = acc_wr && hit_mend;
		mdata_wr = acc_wr && hit_mdata;
		ctrl_wr = acc_wr && hit_ctrl && CRB_MODE;
		ctrl_set = (ctrl_wr && ACC_WDATA[lad_pkg::CTRL_REQ_BIT]) ?
			acc_oh : 5'h00;
		release_req = RELINQUISH || (ctrl_wr &&
			ACC_WDATA[lad_pkg::CTRL_REL_BIT] && |(acc_oh & act_r));
		hi_req = top_bit(req_r);
		hi_seize = top_bit(SEIZE_LEVEL);
	end

	// ======================================================================
	// Ownership state machine
	always_comb begin
		state_nxt = state_r;
		act_nxt = act_r;
		grant = 5'h00;
		start_ok = 1'b0;
		end_ok = 1'b0;
		ignored = 1'b0;
		case (state_r)
			lad_pkg::ST_FREE: begin
				if (mstart_wr) begin
					act_nxt = lad_pkg::TOP_LVL_OH;
					state_nxt = lad_pkg::ST_MEAS;
					start_ok = 1'b1;
				end else if (|req_r) begin
					act_nxt = hi_req;
					grant = hi_req;
					state_nxt = lad_pkg::ST_OWNED;
				end
				ignored = mend_wr || mdata_wr;
			end
			lad_pkg::ST_OWNED: begin
				if (mstart_wr) begin
					if (act_r[lad_pkg::TOP_LVL]) begin
						state_nxt = lad_pkg::ST_MEAS;
						start_ok = 1'b1;
					end else begin
						ignored = 1'b1;
					end
				end else if (release_req) begin
					// Pending requests take over without a free cycle
					if (|req_r) begin
						act_nxt = hi_req;
						grant = hi_req;
					end else begin
						act_nxt = lad_pkg::NO_LVL_OH;
						state_nxt = lad_pkg::ST_FREE;
					end
				end else if (hi_seize > act_r) begin
					act_nxt = hi_seize;
				end
				if (mend_wr || mdata_wr) begin
					ignored = 1'b1;
				end
			end
			lad_pkg::ST_MEAS: begin
				// Requests wait: level 4 already holds top priority
				if (mend_wr) begin
					act_nxt = lad_pkg::NO_LVL_OH;
					state_nxt = lad_pkg::ST_FREE;
					end_ok = 1'b1;
				end else if (mstart_wr) begin
					start_ok = 1'b1;
				end
			end
			default: begin
				act_nxt = lad_pkg::NO_LVL_OH;
				state_nxt = lad_pkg::ST_FREE;
			end
		endcase
		// A new request in the grant cycle stays pending
		req_nxt = (req_r & ~grant) | REQ_LEVEL | ctrl_set;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= lad_pkg::ST_FREE;
			act_r <= lad_pkg::NO_LVL_OH;
			req_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			act_r <= act_nxt;
			req_r <= req_nxt;
		end
	end

	// ======================================================================
	// Indicator and measurement outputs
	always_comb begin
		LEVEL_ONEHOT_IND = {3'h0, act_r};
		OWNED = |act_r;
		MEAS_ACTIVE = (state_r == lad_pkg::ST_MEAS);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			MEAS_START_STB <= 1'b0;
			MEAS_END_STB <= 1'b0;
			MEAS_DATA_VALID <= 1'b0;
			MEAS_DATA <= 8'h00;
			CMD_IGNORED <= 1'b0;
		end else begin
			MEAS_START_STB <= start_ok;
			MEAS_END_STB <= end_ok;
			MEAS_DATA_VALID <= mdata_wr && (state_r == lad_pkg::ST_MEAS);
			if (mdata_wr) begin
				MEAS_DATA <= ACC_WDATA;
			end
			CMD_IGNORED <= ignored;
		end
	end

	// ======================================================================
	// Level checks and decode results
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RES_GRANT <= 1'b0;
			RES_DENY <= 1'b0;
			ACC_REFUSED <= 1'b0;
		end else begin
			RES_GRANT <= RES_VALID && |(RES_LEVELS & act_r);
			RES_DENY <= RES_VALID && !(|(RES_LEVELS & act_r));
			ACC_REFUSED <= ACC_VALID && hit_data &&
				!(|(acc_oh & act_r));
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ACC_LEVEL <= 3'h0;
			SEL_CTRL <= 1'b0;
			SEL_STATUS <= 1'b0;
			SEL_DATA <= 1'b0;
			SEL_NONE <= 1'b0;
		end else begin
			if (ACC_VALID && dec_ok) begin
				ACC_LEVEL <= dec_lvl;
			end
			SEL_CTRL <= ACC_VALID && hit_ctrl;
			SEL_STATUS <= ACC_VALID && hit_sts;
			SEL_DATA <= ACC_VALID && hit_data;
			SEL_NONE <= ACC_VALID && hit_none;
		end
	end

	// ======================================================================
	// Checks
	a_begin_ignored:
	assert property (@(posedge CLK) disable iff (!RST_N)
		mstart_wr && state_r == lad_pkg::ST_OWNED && !act_r[4]
		|=> act_r == $past(act_r) && CMD_IGNORED && !MEAS_ACTIVE)
	else $error("begin not ignored under lower owner");

	a_begin_free:
	assert property (@(posedge CLK) disable iff (!RST_N)
		mstart_wr && state_r == lad_pkg::ST_FREE
		|=> LEVEL_ONEHOT_IND == 8'h10 && MEAS_ACTIVE && MEAS_START_STB)
	else $error("begin in free state did not take level 4");

	a_end_release:
	assert property (@(posedge CLK) disable iff (!RST_N)
		mend_wr && MEAS_ACTIVE
		|=> LEVEL_ONEHOT_IND == 8'h00 && !OWNED && MEAS_END_STB)
	else $error("end did not free the device");

	a_indicator_code:
	assert property (@(posedge CLK) disable iff (!RST_N)
		$onehot0(LEVEL_ONEHOT_IND) && LEVEL_ONEHOT_IND[7:5] == 3'h0
		&& OWNED == (LEVEL_ONEHOT_IND != 8'h00))
	else $error("indicator not one-hot");

	a_grant_priority:
	assert property (@(posedge CLK) disable iff (!RST_N)
		state_r == lad_pkg::ST_FREE && !mstart_wr && req_r != 5'h00
		|=> act_r == $past(hi_req) && act_r > ($past(req_r) & ~act_r))
	else $error("grant not to highest request");

	a_free_accept:
	assert property (@(posedge CLK) disable iff (!RST_N)
		state_r == lad_pkg::ST_FREE && ctrl_set[4] && req_r == 5'h00
		&& !mstart_wr |=> ##1 LEVEL_ONEHOT_IND == 8'h10)
	else $error("top request in free state not accepted");

	a_res_refuse:
	assert property (@(posedge CLK) disable iff (!RST_N)
		RES_VALID && (RES_LEVELS & act_r) == 5'h00
		|=> RES_DENY && !RES_GRANT)
	else $error("mismatched level not refused");

	a_status_mirror:
	assert property (@(posedge CLK) disable iff (!RST_N)
		ACC_VALID && ACC_ADDR[15:12] <= 4'h4 && ACC_ADDR[11:0] >= 12'h018
		&& ACC_ADDR[11:0] <= 12'h01B |=> SEL_STATUS && !SEL_NONE)
	else $error("status not selected in a level window");

	a_data_alias:
	assert property (@(posedge CLK) disable iff (!RST_N)
		ACC_VALID && ACC_ADDR[15:12] <= 4'h4 && ACC_ADDR[11:2] == 10'h009
		|=> SEL_DATA)
	else $error("data port byte not aliased");

	a_meas_window:
	assert property (@(posedge CLK) disable iff (!RST_N)
		ACC_VALID && ACC_WRITE && ACC_ADDR[15:12] != 4'h4
		|=> !MEAS_START_STB && !MEAS_END_STB && !MEAS_DATA_VALID)
	else $error("measurement command outside level 4 window");

	a_level_field:
	assert property (@(posedge CLK) disable iff (!RST_N)
		ACC_VALID && ACC_ADDR[15:12] <= 4'h4
		|=> ACC_LEVEL == $past(ACC_ADDR[14:12]))
	else $error("access level not from address bits");
endmodule
`default_nettype wire

/* lad_host_model.sv */
// Host-side model that issues locality-tagged byte cycles to the arbiter
`timescale 1ns/10ps
`default_nettype none
module lad_host_model (
	input  wire logic        clk,       // Bus clock
	output logic             acc_valid, // Cycle strobe
	output logic             acc_write, // Write cycle
	output logic      [15:0] acc_addr,  // Byte address
	output logic      [7:0]  acc_wdata  // Write byte
);
	// ======================================================================
	// Idle bus
	initial begin
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_addr  = 16'h0000;
		acc_wdata = 8'h00;
	end

	// ======================================================================
	// One byte cycle; the caller sits just after a rising edge
	task automatic cycle(input logic wr, input logic [15:0] a,
		input logic [7:0] d, input logic trusted);
		// Only the trust root reaches the top window, whole range blocked
		acc_valid = !(a[15:12] == 4'h4 && !trusted);
		acc_write = wr;
		acc_addr  = a;
		acc_wdata = d;
		@(posedge clk);
		#1;
		// Request stays up, so back-to-back cycles never retoggle the strobe
	endtask

	// ======================================================================
	// Release the bus; the caller sits just after a rising edge
	task automatic idle();
		if (acc_valid) begin
			// Released lines show the inverse, never a stale copy
			acc_valid = 1'b0;
			acc_write = ~acc_write;
			acc_addr  = ~acc_addr;
			acc_wdata = ~acc_wdata;
		end
	endtask
endmodule
`default_nettype wire

/* lad_arbiter_tb_top.sv */
// Self-checking testbench for the locality arbiter and decoder
`timescale 1ns/10ps
`default_nettype none
module lad_arbiter_tb_top;
	logic        clk;
	logic        rst_n;
	logic        acc_valid;
	logic        acc_write;
	logic [15:0] acc_addr;
	logic [7:0]  acc_wdata;
	logic        cmd_resp_buffer_if;
	logic [4:0]  req_lvl;
	logic [4:0]  seize;
	logic        relq;
	logic        res_v;
	logic [4:0]  res_l;
	logic [7:0]  ind;
	logic        owned;
	logic        meas_act;
	logic        start_stb;
	logic        end_stb;
	logic        mdv;
	logic [7:0]  mdata;
	logic        ignored;
	logic        res_g;
	logic        res_d;
	logic        refused;
	logic [2:0]  acc_lvl;
	logic        sel_ctrl;
	logic        sel_sts;
	logic        sel_data;
	logic        sel_none;
	int          fail_count;
	int          checked;

	lad_arbiter u_lad_arbiter (.CLK(clk), .RST_N(rst_n),
		.ACC_VALID(acc_valid), .ACC_WRITE(acc_write), .ACC_ADDR(acc_addr),
		.ACC_WDATA(acc_wdata), .CRB_MODE(cmd_resp_buffer_if), .REQ_LEVEL(req_lvl),
		.SEIZE_LEVEL(seize), .RELINQUISH(relq), .RES_VALID(res_v),
		.RES_LEVELS(res_l), .LEVEL_ONEHOT_IND(ind), .OWNED(owned),
		.MEAS_ACTIVE(meas_act), .MEAS_START_STB(start_stb),
		.MEAS_END_STB(end_stb), .MEAS_DATA_VALID(mdv), .MEAS_DATA(mdata),
		.CMD_IGNORED(ignored), .RES_GRANT(res_g), .RES_DENY(res_d),
		.ACC_REFUSED(refused), .ACC_LEVEL(acc_lvl), .SEL_CTRL(sel_ctrl),
		.SEL_STATUS(sel_sts), .SEL_DATA(sel_data), .SEL_NONE(sel_none));

	lad_host_model u_lad_host_model (.clk(clk), .acc_valid(acc_valid),
		.acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata));

	// ======================================================================
	// Clock and helpers
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic tick();
		u_lad_host_model.idle();
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask

	// Grants take a pending edge first, so poll a few cycles only
	task automatic wait_ind(input logic [7:0] exp);
		for (int i = 0; i < 6 && ind !== exp; i++)
			tick();
		chk(ind, exp, "indicator");
	endtask

	task automatic acc(input logic wr, input logic [15:0] a,
		input logic [7:0] d);
		u_lad_host_model.cycle(wr, a, d, 1'b1);
	endtask

	task automatic req(input logic [4:0] m);
		req_lvl = m;
		tick();
		req_lvl = 5'h00;
	endtask

	task automatic rel();
		relq = 1'b1;
		tick();
		relq = 1'b0;
	endtask

	function automatic logic [7:0] oh(input int l);
		return 8'h01 << l;
	endfunction

	function automatic int top(input logic [4:0] m);
		int r;
		r = 0;
		for (int i = 0; i < 5; i++)
			if (m[i])
				r = i;
		return r;
	endfunction

	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ======================================================================
	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		final_report();
	end

	// ======================================================================
	// Tests
	initial begin
		logic [7:0]  b;
		logic [4:0]  m;
		logic [11:0] k;
		rst_n = 1'b0;
		cmd_resp_buffer_if = 1'b0;
		req_lvl = 5'h00;
		seize = 5'h00;
		relq = 1'b0;
		res_v = 1'b0;
		res_l = 5'h00;
		fail_count = 0;
		checked = 0;
		void'($urandom(81510));
		repeat (10) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk(ind, 8'h00, "reset indicator");
		chk({7'h00, owned}, 8'h00, "reset owned");
		$display("test reset done");

		acc(1'b1, 16'h4028, 8'h00);
		chk({7'h00, start_stb}, 8'h01, "begin strobe");
		chk(ind, 8'h10, "begin indicator");
		for (int j = 0; j < 4; j++) begin
			b = 8'($urandom);
			acc(1'b1, 16'h402C + 16'(j), b);
			chk({7'h00, mdv}, 8'h01, "data strobe");
			chk(mdata, b, "data byte");
		end
		acc(1'b1, 16'h4029, 8'h00);
		chk({7'h00, end_stb}, 8'h01, "end strobe");
		chk({7'h00, meas_act}, 8'h00, "end active");
		chk(ind, 8'h00, "end indicator");
		$display("test measurement done");

		for (int l = 0; l < 5; l++) begin
			req(5'(1 << l));
			wait_ind(oh(l));
			chk({7'h00, owned}, 8'h01, "owned");
			m = 5'($urandom);
			res_l = m;
			res_v = 1'b1;
			tick();
			res_v = 1'b0;
			chk({6'h00, res_g, res_d}, {6'h00, m[l], !m[l]}, "policy");
			rel();
			wait_ind(8'h00);
		end
		$display("test levels done");

		for (int n = 0; n < 4; n++) begin
			m = (n == 0) ? 5'b00101 : 5'($urandom);
			req(m);
			wait_ind(m == 5'h00 ? 8'h00 : oh(top(m)));
			while (m != 5'h00) begin
				m[top(m)] = 1'b0;
				rel();
				wait_ind(m == 5'h00 ? 8'h00 : oh(top(m)));
			end
		end
		req(5'b00010);
		wait_ind(8'h02);
		seize = 5'b01000;
		tick();
		seize = 5'h00;
		chk(ind, 8'h08, "seize higher");
		seize = 5'b00100;
		tick();
		seize = 5'h00;
		chk(ind, 8'h08, "seize lower");
		rst_n = 1'b0;
		tick();
		chk(ind, 8'h00, "mid reset");
		rst_n = 1'b1;
		tick();
		chk(ind, 8'h00, "after reset");
		$display("test priority done");

		req(5'b00010);
		wait_ind(8'h02);
		for (int l = 0; l < 6; l++) begin
			k = 12'($urandom % 4);
			acc(1'b0, {4'(l), 12'h018 + k}, 8'h00);
			chk({6'h00, sel_sts, sel_none}, l < 5 ? 8'h02 : 8'h01, "sts");
			if (l < 5)
				chk({5'h00, acc_lvl}, 8'(l), "level");
			acc(1'b0, {4'(l), 12'h024 + k}, 8'h00);
			chk({6'h00, sel_data, refused},
				l == 1 ? 8'h02 : (l < 5 ? 8'h03 : 8'h00), "port");
			acc(1'b0, {4'(l), 12'h01C + k}, 8'h00);
			chk({7'h00, sel_none}, 8'h01, "gap");
			acc(1'b1, {4'(l), 12'h028}, 8'($urandom));
			chk({6'h00, sel_none, ignored}, l == 4 ? 8'h01 : 8'h02, "begin");
			chk(ind, 8'h02, "owner kept");
		end
		rel();
		wait_ind(8'h00);
		$display("test decode done");

		cmd_resp_buffer_if = 1'b1;
		acc(1'b1, 16'h4008, 8'h01);
		chk({7'h00, sel_ctrl}, 8'h01, "ctrl select");
		wait_ind(8'h10);
		acc(1'b1, 16'h4008, 8'h02);
		wait_ind(8'h00);
		cmd_resp_buffer_if = 1'b0;
		$display("test control done");
		final_report();
	end
endmodule
`default_nettype wire
